// file: rtl/llc_protection_sequencer.sv
// Fault supervisor and operating-state sequencer of a half-bridge resonant controller.
// Assumes asynchronous comparator levels and static version straps; APB reaches registers.
// Overview of operation
// - Qualified faults latch or auto-recover per version
// - Power limit clamps, or after the fault timer latches or recovers per version
// - Thermal stop after 10us, startup source off
// - Hot die stops drivers at once, flag kept
// - Overvoltage/overtemperature window filtered before stopping
// - Crossed threshold selects latch or recovery
// - Overtemperature comparator ignored during its blanking
// - Doubled bias current during overtemperature blanking
// - Window block enabled on reset, restarts
// - Overtemperature bias off when drivers stop
// - Window block off in skip unless optioned
// - Hysteretic overtemperature stops low, restarts high
// - Latch holds while supply cycles on/off
// - Start blanking masks faults after reset
// - On level enables PFC; stop keeps self-supply
// - Bulk good recharges supply, then drivers start
// - Bulk loss stops drivers, PFC stays high
// - Restart only through regular startup sequence, except hysteretic overtemperature resume straight to run
// - Latch-off keeps only supply management alive
// - Recovery delay then new blanking and restart
`timescale 1ns/1ps
`default_nettype none
`include "llc_prot_regs.svh"

module llc_protection_sequencer
  import llc_prot_pkg::*;
#(
  parameter logic [19:0] START_BLANK_CYC = 20'h00fa0,
  parameter logic [19:0] OTP_BLANK_CYC   = 20'h00fa0,
  parameter logic [19:0] FILTER_CYC      = 20'h00050,
  parameter logic [19:0] FAULT_CYC       = 20'h01f40,
  parameter logic [19:0] RECOV_CYC       = 20'h9c400,
  parameter logic [19:0] EVENT_LIMIT     = 20'h00008
) (
  // Clock and reset.
  input  wire logic                    CORE_CLK,
  input  wire logic                    RESETN,
  // Comparator and supply levels.
  input  wire cmp_t                    CMP_IN,
  // Version straps.
  input  wire cfg_t                    CFG_IN,
  // APB slave.
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [`LLC_ADDR_W-1:0]  PADDR,
  input  wire logic [31:0]             PWDATA,
  output logic      [31:0]             PRDATA,
  output logic                         PREADY,
  output logic                         PSLVERR,
  // Power stage control.
  output ctl_t                         CTRL_OUT
);

  localparam int CW = `LLC_CNT_W;
  localparam logic [CW-1:0] TQUAL = CW'(`LLC_TQUAL_CYC);

  state_t          state;
  state_t          next_state;
  cmp_t            cmp_s1;
  cmp_t            cmp_s2;
  cmp_t            cmp_s3;
  cfg_t            cfg_s1;
  cfg_t            cfg_s2;
  cfg_t            cfg;
  logic [1:0]      cfg_age;
  logic [CW-1:0]   blank_cnt;
  logic [CW-1:0]   otp_blank_cnt;
  logic [CW-1:0]   recov_cnt;
  logic [4:0]      lvl;
  logic [4:0]      lvl_en;
  logic [4:0]      qual;
  logic [1:0]      evq;
  logic            stop_req;
  logic            overvolt_overtemp_input_on;
  logic            flag;
  ctl_t            next_ctl;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  // Two flops on every asynchronous level; a third flop feeds edge detection only.
  // two-flop synchronizer.
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cmp_s1 <= '0;
      cmp_s2 <= '0;
      cmp_s3 <= '0;
      cfg_s1 <= '0;
      cfg_s2 <= '0;
    end else begin
      cmp_s1 <= CMP_IN;
      cmp_s2 <= cmp_s1;
      cmp_s3 <= cmp_s2;
      cfg_s1 <= CFG_IN;
      cfg_s2 <= cfg_s1;
    end
  end

  // Straps are taken once the synchronizer has filled after reset release.
  // straps sampled once.
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cfg_age <= '0;
      cfg     <= '0;
    end else if (cfg_age != `LLC_CFG_AGE_MAX) begin
      cfg_age <= cfg_age + 2'h1;
      cfg     <= cfg_s2;
    end
  end

  // Qualifier channels: fault timer, overvoltage, overtemperature, low supply, thermal.
  // power limit joins the timer only when not clamping.
  assign lvl[0] = cmp_s2.cs_peak | cmp_s2.fb_clamp | (cmp_s2.power_limit & ~cfg.cp_no_timer);
  assign lvl[1] = cmp_s2.ovp_high;
  assign lvl[2] = cmp_s2.otp_low & (otp_blank_cnt == '0);
  assign lvl[3] = cmp_s2.supply_off_low;
  assign lvl[4] = cmp_s2.thermal_hot;
  // nothing qualifies inside the start blanking.
  assign lvl_en = {(state != ST_BLANK), {4{state == ST_RUN}}};

  // One counter per qualifier; a channel is qualified once its level lasts the threshold.
  // window filter delay.
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_qual
      logic [CW-1:0] cnt;
      logic [CW-1:0] thr;
      assign thr = (gi == 0) ? FAULT_CYC : ((gi == 1 || gi == 2) ? FILTER_CYC : TQUAL);
      assign qual[gi] = (cnt >= thr);
      always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
          cnt <= '0;
        end else if (!lvl_en[gi] || !lvl[gi]) begin
          cnt <= '0;
        end else if (!qual[gi]) begin
          cnt <= cnt + CW'(1);
        end
      end
    end
    // Event counters for maximum on-time and maximum dead-time.
    // event counter qualification.
    for (gi = 0; gi < 2; gi++) begin : g_evt
      logic [CW-1:0] ecnt;
      logic          edge_seen;
      assign edge_seen = (gi == 0) ? (cmp_s2.ton_max_evt & ~cmp_s3.ton_max_evt)
                                   : (cmp_s2.dt_max_evt & ~cmp_s3.dt_max_evt);
      assign evq[gi] = (ecnt >= EVENT_LIMIT);
      always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
          ecnt <= '0;
        end else if (state != ST_RUN) begin
          ecnt <= '0;
        end else if (edge_seen && !evq[gi]) begin
          ecnt <= ecnt + CW'(1);
        end
      end
    end
  endgenerate

  // Fault classes and the latch-or-recover choice.
  wire ovp_f      = qual[1];
  wire otp_f      = qual[2] & ~cfg.hyst_otp;
  wire other_f    = qual[0] | evq[0] | evq[1] | qual[3];
  wire any_f      = ovp_f | otp_f | other_f;
  // crossed threshold picks the version bit.
  wire use_recov  = ovp_f ? cfg.ovp_auto : (otp_f ? cfg.otp_auto : cfg.auto_recover);
  wire start_ok   = cmp_s2.bulk_voltage_good & cmp_s2.hv_start_ok & ~stop_req;
  wire run_entry  = (state != ST_RUN) && (next_state == ST_RUN);
  wire to_blank   = (state != ST_BLANK) && (next_state == ST_BLANK);

  // Operating-state sequencer.
  always_comb begin
    next_state = state;
    unique case (state)
      // blank window then wait for supply.
      ST_BLANK: begin
        if (blank_cnt == '0) begin
          next_state = ST_CHARGE;
        end
      end
      // on level decides run or self-supply.
      ST_CHARGE: begin
        if (qual[4]) begin
          next_state = ST_THERM;
        end else if (cmp_s2.supply_on) begin
          next_state = start_ok ? ST_RUN : ST_SELF;
        end
      end
      ST_SELF: begin
        if (qual[4]) begin
          next_state = ST_THERM;
        end else if (start_ok) begin
          next_state = ST_BLANK;
        end
      end
      ST_RUN: begin
        if (qual[4]) begin
          next_state = ST_THERM;
        end else if (any_f) begin
          next_state = use_recov ? ST_RECOV : ST_LATCH;
        end else if (!start_ok) begin
          next_state = ST_SELF;
        end else if (qual[2] && cfg.hyst_otp) begin
          next_state = ST_HYST;
        end
      end
      ST_HYST: begin
        if (qual[4]) begin
          next_state = ST_THERM;
        end else if (!start_ok) begin
          next_state = ST_SELF;
        end else if (!cmp_s2.otp_low) begin
          next_state = ST_RUN;
        end
      end
      // only the high-voltage release frees the latch.
      ST_LATCH: begin
        if (cmp_s2.hv_release) begin
          next_state = ST_BLANK;
        end
      end
      ST_RECOV: begin
        if (recov_cnt == '0) begin
          next_state = ST_BLANK;
        end
      end
      // resume on line, supply and cool die.
      ST_THERM: begin
        if (!cmp_s2.thermal_hot && cmp_s2.hv_start_ok && cmp_s2.supply_on) begin
          next_state = ST_BLANK;
        end
      end
    endcase
  end

  // State register and the window counters.
  // every restart except the resume from hysteresis passes blanking and charge.
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state         <= ST_BLANK;
      blank_cnt     <= START_BLANK_CYC;
      otp_blank_cnt <= '0;
      recov_cnt     <= '0;
    end else begin
      state         <= next_state;
      blank_cnt     <= to_blank ? START_BLANK_CYC : (blank_cnt - CW'(blank_cnt != '0));
      otp_blank_cnt <= run_entry ? OTP_BLANK_CYC
                                 : (otp_blank_cnt - CW'(otp_blank_cnt != '0));
      recov_cnt     <= (next_state == ST_RECOV && state != ST_RECOV) ? RECOV_CYC
                                 : (recov_cnt - CW'(recov_cnt != '0));
    end
  end

  // Window block enable and the retained thermal flag; a set wins over a clear.
  // enable on reset and on restart.
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      overvolt_overtemp_input_on <= 1'h1;
      flag       <= 1'h0;
    end else begin
      if (run_entry && state != ST_HYST) begin
        overvolt_overtemp_input_on <= 1'h1;
      end else if (next_state inside {ST_SELF, ST_LATCH, ST_RECOV, ST_THERM}) begin
        overvolt_overtemp_input_on <= 1'h0;
      end
      if (qual[4]) begin
        flag <= 1'h1;
      end else if (!cmp_s2.thermal_hot) begin
        flag <= 1'h0;
      end
    end
  end

  // Output decode from the state and the synchronized levels.
  // drivers drop as soon as the die is hot.
  assign next_ctl.half_bridge_gate_drives = (state == ST_RUN) & ~cmp_s2.thermal_hot;
  // PFC output stays high in self-supply.
  assign next_ctl.pfc_stage_control_out   = state inside {ST_SELF, ST_RUN, ST_HYST};
  assign next_ctl.hv_source_en            = state inside {ST_BLANK, ST_CHARGE};
  assign next_ctl.dynamic_self_supply     = state inside {ST_SELF, ST_LATCH, ST_RECOV};
  assign next_ctl.analog_en               = !(state inside {ST_LATCH, ST_RECOV, ST_THERM});
  // window block bias in skip only when optioned.
  assign next_ctl.overvolt_overtemp_input_bias            = overvolt_overtemp_input_on & ~(cmp_s2.skip_mode & ~cfg.skip_active);
  assign next_ctl.overtemp_bias_en        = next_ctl.half_bridge_gate_drives;
  assign next_ctl.overtemp_bias_boost     = next_ctl.half_bridge_gate_drives
                                            & (otp_blank_cnt != '0);
  assign next_ctl.constant_power          = (state == ST_RUN) & cmp_s2.power_limit
                                            & cfg.cp_no_timer;
  assign next_ctl.thermal_shutdown_flag   = flag;
  assign next_ctl.start_blank             = (state == ST_BLANK);

  // Registered control outputs.
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      CTRL_OUT <= '0;
    end else begin
      CTRL_OUT <= next_ctl;
    end
  end

  // APB decode; the slave answers in the second access cycle.
  wire        apb_acc = PSEL & PENABLE & ~PREADY;
  wire        hit_ctl = (PADDR == `LLC_REG_CTRL);
  wire        hit_st  = (PADDR == `LLC_REG_STATUS);
  wire        wr_ctl  = PSEL & PENABLE & PREADY & PWRITE & hit_ctl;
  wire [31:0] rd_mux  = hit_ctl ? {31'h0, stop_req}
                      : (hit_st ? {26'h0, CTRL_OUT.half_bridge_gate_drives, overvolt_overtemp_input_on,
                                   flag, state} : 32'h0);

  // Bus answer and the software stop request.
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      PREADY   <= 1'h0;
      PSLVERR  <= 1'h0;
      PRDATA   <= '0;
      stop_req <= `LLC_CTRL_RESET;
    end else begin
      PREADY  <= apb_acc;
      PSLVERR <= apb_acc & ~(hit_ctl | hit_st);
      if (apb_acc && !PWRITE) begin
        PRDATA <= rd_mux;
      end
      if (wr_ctl) begin
        stop_req <= PWDATA[`LLC_CTRL_STOP_BIT];
      end
    end
  end

  // Checks on the sequencer.
  a_sync_delay: assert property (cmp_s2 == $past(cmp_s1))
    else $error("Comparator sync stage skipped.");
  a_blank_masks: assert property (state == ST_BLANK |-> qual[3:0] == 4'h0)
    else $error("Fault qualified inside start blanking.");
  a_latch_holds: assert property ((state == ST_LATCH) && !cmp_s2.hv_release
    |=> state == ST_LATCH)
    else $error("Latch left without release.");
  a_therm_hv_off: assert property (state == ST_THERM |=> !CTRL_OUT.hv_source_en)
    else $error("Startup source on in thermal stop.");
  a_hot_drv_off: assert property (cmp_s2.thermal_hot
    |=> !CTRL_OUT.half_bridge_gate_drives)
    else $error("Drivers on with hot die.");
  a_bias_follows: assert property (CTRL_OUT.overtemp_bias_en
    |-> CTRL_OUT.half_bridge_gate_drives)
    else $error("Overtemp bias on while drivers stopped.");
  a_boost_window: assert property (run_entry |=> ##1 (CTRL_OUT.overtemp_bias_boost
    || $past(cmp_s2.thermal_hot) || OTP_BLANK_CYC == '0))
    else $error("No bias boost at driver start.");
  a_pfc_on_level: assert property ((state == ST_CHARGE) && cmp_s2.supply_on
    && !qual[4] |=> ##1 CTRL_OUT.pfc_stage_control_out)
    else $error("PFC output not raised at on level.");
  a_bulk_loss: assert property ((state == ST_RUN) && !cmp_s2.bulk_voltage_good
    && !any_f && !qual[4] |=> state == ST_SELF ##1
    (CTRL_OUT.pfc_stage_control_out && !CTRL_OUT.overvolt_overtemp_input_bias))
    else $error("Bulk loss not handled.");
  a_hyst_no_en: assert property ((state == ST_HYST) && (next_state == ST_RUN)
    |=> overvolt_overtemp_input_on == $past(overvolt_overtemp_input_on))
    else $error("Window block re-enabled from hysteresis.");
  a_recov_blank: assert property ((state == ST_RECOV) && (recov_cnt == '0)
    |=> state == ST_BLANK ##1 CTRL_OUT.hv_source_en)
    else $error("Recovery did not restart blanking.");
  a_fault_stop: assert property ((state == ST_RUN) && any_f && !qual[4]
    |=> state inside {ST_LATCH, ST_RECOV})
    else $error("Qualified fault ignored.");
  a_latch_quiet: assert property (state == ST_LATCH
    |=> (CTRL_OUT.dynamic_self_supply && !CTRL_OUT.analog_en))
    else $error("Latch keeps blocks alive.");

  c_run: cover property (state == ST_CHARGE ##1 state == ST_RUN);
  c_latch: cover property (state == ST_RUN ##1 state == ST_LATCH);
  c_recov: cover property (state == ST_RECOV ##1 state == ST_BLANK);
  c_hyst: cover property (state == ST_HYST ##1 state == ST_RUN);

endmodule

`default_nettype wire

// file: rtl/llc_prot_regs.svh
// Register offsets, status field positions and timing counts of the protection sequencer.
// Assumes a 40 MHz core clock and a byte-addressed APB register window.
`ifndef LLC_PROT_REGS_SVH
`define LLC_PROT_REGS_SVH

`define LLC_ADDR_W         8
`define LLC_REG_CTRL       8'h00
`define LLC_REG_STATUS     8'h04
`define LLC_CTRL_STOP_BIT  0
`define LLC_ST_STATE_LSB   0
`define LLC_ST_FLAG_BIT    3
`define LLC_ST_OVPON_BIT   4
`define LLC_ST_DRV_BIT     5
`define LLC_CTRL_RESET     1'h0
`define LLC_CLK_NS         25
`define LLC_TQUAL_NS       10000
`define LLC_TQUAL_CYC      ((`LLC_TQUAL_NS + `LLC_CLK_NS - 1) / `LLC_CLK_NS)
`define LLC_CNT_W          20
`define LLC_CFG_AGE_MAX    2'h3

`endif

// file: rtl/llc_prot_pkg.sv
// Types shared by the protection sequencer: states and packed signal groups.
// Assumes the comparator flags arrive as plain levels from the analog front end.
package llc_prot_pkg;

  typedef enum logic [2:0] {
    ST_BLANK  = 3'b000,
    ST_CHARGE = 3'b001,
    ST_SELF   = 3'b010,
    ST_RUN    = 3'b011,
    ST_HYST   = 3'b100,
    ST_LATCH  = 3'b101,
    ST_RECOV  = 3'b110,
    ST_THERM  = 3'b111
  } state_t;

  typedef struct packed {
    logic supply_on;
    logic supply_off_low;
    logic bulk_voltage_good;
    logic hv_start_ok;
    logic hv_release;
    logic thermal_hot;
    logic ovp_high;
    logic otp_low;
    logic cs_peak;
    logic fb_clamp;
    logic power_limit;
    logic ton_max_evt;
    logic dt_max_evt;
    logic skip_mode;
  } cmp_t;

  typedef struct packed {
    logic auto_recover;
    logic ovp_auto;
    logic otp_auto;
    logic skip_active;
    logic hyst_otp;
    logic cp_no_timer;
  } cfg_t;

  typedef struct packed {
    logic half_bridge_gate_drives;
    logic pfc_stage_control_out;
    logic hv_source_en;
    logic dynamic_self_supply;
    logic analog_en;
    logic overvolt_overtemp_input_bias;
    logic overtemp_bias_en;
    logic overtemp_bias_boost;
    logic constant_power;
    logic thermal_shutdown_flag;
    logic start_blank;
  } ctl_t;

endpackage

// file: sim/llc_front_model.sv
// Front end model: supply capacitor and comparator levels around the sequencer.
// Assumes the sequencer's control outputs decide whether the supply charges.
`timescale 1ns/1ps
`default_nettype none

module llc_front_model
  import llc_prot_pkg::*;
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic resetn,
  // Sequencer control and bench levels.
  input  wire ctl_t ctl,
  input  wire cmp_t knobs,
  // Comparator levels seen by the sequencer.
  output var  cmp_t cmp
);
  localparam int OnLvl  = 40;
  localparam int OffLvl = 10;
  int   vcc;
  logic chg;

  // Supply rises on the startup source or drivers and hiccups in self-supply.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vcc <= 0;
      chg <= 1'b1;
    end else begin
      if (vcc >= OnLvl) chg <= 1'b0;
      else if (vcc <= OffLvl) chg <= 1'b1;
      if (ctl.hv_source_en || ctl.half_bridge_gate_drives || (ctl.dynamic_self_supply && chg))
        vcc <= (vcc < 63) ? vcc + 1 : vcc;
      else if (vcc > 0) vcc <= vcc - 1;
    end
  end

  // Bench levels pass through; the supply comparators come from the capacitor.
  always_comb begin
    cmp = knobs;
    cmp.supply_on = (vcc >= OnLvl);
    cmp.supply_off_low = (vcc < OffLvl);
  end
endmodule

`default_nettype wire

// file: sim/llc_protection_sequencer_test.sv
// Self-checking bench of the protection sequencer with a front end model.
// Assumes APB registers CTRL and STATUS and shortened qualification counts.
`timescale 1ns/1ps
`default_nettype none
`include "llc_prot_regs.svh"

module llc_protection_sequencer_test
  import llc_prot_pkg::*;
;
  logic core_clk, resetn, psel, penable, pwrite, pready, pslverr, err;
  logic [`LLC_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  cmp_t cmp_in, knobs;
  cfg_t cfg;
  ctl_t ctl;
  int   num_errors, checked, cycles, hits;

  llc_protection_sequencer #(
    .START_BLANK_CYC(20'h00008), .OTP_BLANK_CYC(20'h00008),
    .FAULT_CYC(20'h00010), .RECOV_CYC(20'h00020), .EVENT_LIMIT(20'h00002)
  ) uut (
    .CORE_CLK(core_clk), .RESETN(resetn), .CMP_IN(cmp_in), .CFG_IN(cfg),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CTRL_OUT(ctl)
  );

  llc_front_model fm (.clk(core_clk), .resetn(resetn), .ctl(ctl), .knobs(knobs), .cmp(cmp_in));

  // Clock of 25 ns.
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Cuts a hang short.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk1(input string what, input logic seen, input logic exp);
    check(what, {31'h0, seen}, {31'h0, exp});
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic look();
    @(negedge core_clk);
  endtask

  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk1("pready", pready, 1'b1);
  endtask

  task automatic wait_state(input state_t s, input int lim);
    int n;
    n = 0;
    do begin
      apb(1'b0, `LLC_REG_STATUS, 32'h0);
      n++;
    end while (rd[2:0] !== s && n < lim);
    check("state", {29'h0, rd[2:0]}, {29'h0, s});
  endtask

  task automatic do_reset(input cfg_t c);
    @(posedge core_clk);
    cfg <= c;
    resetn <= 1'b0;
    look();
    check("ctl in reset", {21'h0, ctl}, 32'h0);
    cyc(2);
    resetn <= 1'b1;
    cyc(1);
    look();
    chk1("start_blank", ctl.start_blank, 1'b1);
    chk1("analog_en", ctl.analog_en, 1'b1);
    chk1("hv_source", ctl.hv_source_en, 1'b1);
    // Skip level and straps reach the window bias only once both synchronizers have filled.
    cyc(4);
    look();
    chk1("window", ctl.overvolt_overtemp_input_bias, !(knobs.skip_mode && !c.skip_active));
  endtask

  // Drives one fault input high for a number of cycles.
  task automatic pulse(input int f, input int len);
    knobs[7-f] <= 1'b1;
    cyc(len);
    knobs[7-f] <= 1'b0;
    cyc(4);
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    resetn = 1'b0;
    cfg = '0;
    knobs = '0;
    knobs.hv_start_ok = 1'b1;
    seed = 32'he6901a5a;
    do_reset('0);
    apb(1'b0, `LLC_REG_CTRL, 32'h0);
    check("ctrl reset", rd, {31'h0, `LLC_CTRL_RESET});
    apb(1'b1, `LLC_REG_CTRL, 32'h1);
    apb(1'b0, `LLC_REG_CTRL, 32'h0);
    check("ctrl back", {31'h0, rd[0]}, 32'h1);
    chk1("slverr", err, 1'b0);
    apb(1'b1, `LLC_REG_STATUS, 32'hffffffff);
    apb(1'b0, 8'h08, 32'h0);
    chk1("unmapped err", err, 1'b1);
    check("unmapped rd", rd, 32'h0);
    apb(1'b1, `LLC_REG_CTRL, 32'h0);
    wait_state(ST_SELF, 100);
    look();
    chk1("pfc", ctl.pfc_stage_control_out, 1'b1);
    chk1("drv self", ctl.half_bridge_gate_drives, 1'b0);
    chk1("dss self", ctl.dynamic_self_supply, 1'b1);
    cyc(1);
    knobs.bulk_voltage_good <= 1'b1;
    wait_state(ST_RUN, 100);
    look();
    chk1("drv run", ctl.half_bridge_gate_drives, 1'b1);
    chk1("window run", ctl.overvolt_overtemp_input_bias, 1'b1);
    cyc(1);
    knobs.bulk_voltage_good <= 1'b0;
    cyc(10);
    look();
    chk1("drv bulk", ctl.half_bridge_gate_drives, 1'b0);
    chk1("window bulk", ctl.overvolt_overtemp_input_bias, 1'b0);
    chk1("otp bias", ctl.overtemp_bias_en, 1'b0);
    chk1("pfc bulk", ctl.pfc_stage_control_out, 1'b1);
    chk1("dss bulk", ctl.dynamic_self_supply, 1'b1);
    cyc(1);
    knobs.bulk_voltage_good <= 1'b1;
    wait_state(ST_RUN, 100);
    apb(1'b1, `LLC_REG_CTRL, 32'h1);
    cyc(10);
    look();
    chk1("drv stop", ctl.half_bridge_gate_drives, 1'b0);
    apb(1'b1, `LLC_REG_CTRL, 32'h0);
    wait_state(ST_RUN, 100);
    // Faults: overvolt_overtemp_input, cs, fb, power limit, on-time and dead-time events.
    for (int f = 0; f < 7; f++) begin
      cyc(20);
      seed = lfsr(seed);
      pulse(f, (f >= 5) ? 4 : (f < 2) ? 1 + seed[0] : 1 + seed[3:0] % 12);
      cyc(30);
      wait_state(ST_RUN, 1);
      if (f >= 5) begin
        pulse(f, 4);
        pulse(f, 4);
      end else begin
        knobs[7-f] <= 1'b1;
      end
      wait_state(ST_LATCH, 60);
      knobs[7-f] <= 1'b0;
      look();
      chk1("drv latch", ctl.half_bridge_gate_drives, 1'b0);
      chk1("dss latch", ctl.dynamic_self_supply, 1'b1);
      chk1("analog latch", ctl.analog_en, 1'b0);
      hits = 0;
      repeat (200) begin
        look();
        hits += ctl.half_bridge_gate_drives;
      end
      check("drv pulses", hits, 32'h0);
      wait_state(ST_LATCH, 1);
      knobs.hv_release <= 1'b1;
      cyc(10);
      knobs.hv_release <= 1'b0;
      wait_state(ST_RUN, 100);
    end
    do_reset('{auto_recover: 1'b1, ovp_auto: 1'b1, otp_auto: 1'b1, default: 1'b0});
    wait_state(ST_RUN, 100);
    cyc(20);
    knobs.cs_peak <= 1'b1;
    wait_state(ST_RECOV, 60);
    knobs.cs_peak <= 1'b0;
    wait_state(ST_RUN, 100);
    knobs.thermal_hot <= 1'b1;
    cyc(6);
    look();
    chk1("drv hot", ctl.half_bridge_gate_drives, 1'b0);
    wait_state(ST_THERM, 200);
    look();
    chk1("hv therm", ctl.hv_source_en, 1'b0);
    chk1("flag", ctl.thermal_shutdown_flag, 1'b1);
    cyc(1);
    knobs.thermal_hot <= 1'b0;
    knobs.skip_mode <= 1'b1;
    // Clamp, hysteresis and per-threshold recovery, with the window kept alive in skip.
    do_reset('{ovp_auto: 1'b1, skip_active: 1'b1, hyst_otp: 1'b1, cp_no_timer: 1'b1,
               default: 1'b0});
    wait_state(ST_RUN, 100);
    knobs.power_limit <= 1'b1;
    cyc(40);
    look();
    chk1("cp clamp", ctl.constant_power, 1'b1);
    chk1("drv clamp", ctl.half_bridge_gate_drives, 1'b1);
    cyc(1);
    knobs.power_limit <= 1'b0;
    knobs.otp_low <= 1'b1;
    wait_state(ST_HYST, 60);
    look();
    chk1("drv hyst", ctl.half_bridge_gate_drives, 1'b0);
    chk1("window hyst", ctl.overvolt_overtemp_input_bias, 1'b1);
    cyc(1);
    knobs.otp_low <= 1'b0;
    wait_state(ST_RUN, 20);
    look();
    chk1("boost", ctl.overtemp_bias_boost, 1'b1);
    cyc(20);
    look();
    chk1("boost end", ctl.overtemp_bias_boost, 1'b0);
    cyc(1);
    knobs.ovp_high <= 1'b1;
    wait_state(ST_RECOV, 60);
    knobs.ovp_high <= 1'b0;
    do_reset('0);
    end_sim();
  end
endmodule

`default_nettype wire
